// file: hdl/flash_status_params.svh
`ifndef FLASH_STATUS_PARAMS_SVH
`define FLASH_STATUS_PARAMS_SVH

// Opcodes
`define OPC_STATUS_READ 8'hd7
`define OPC_DEEP_SLEEP 8'hb9
`define OPC_RESUME 8'hab

// Serial framing
`define BYTE_BITS 8
`define BIT_CNT_W 3
`define STATUS_IDX_W 4
`define BIT_CNT_ZERO 3'h0
`define BIT_CNT_LAST 3'h7
`define STATUS_IDX_ZERO 4'h0
`define STATUS_BYTE_SEL 3

// Status byte one layout
`define ST_READY_BIT 7
`define ST1_COMPARE_BIT 6
`define ST1_DENSITY_MSB 5
`define ST1_DENSITY_LSB 2
`define ST1_PROTECT_BIT 1
`define ST1_PAGE_BIT 0

// Status byte two layout
`define ST2_RSVD_HI_BIT 6
`define ST2_FAIL_BIT 5
`define ST2_RSVD_LO_MSB 4
`define ST2_RSVD_LO_LSB 0
`define ST2_RSVD_LO_ZERO 5'h00

// Reset values
`define FAIL_FLAG_RESET 1'b0
`define SERIAL_OUT_RESET 1'b0

// Timing
`define SYS_CLK_PERIOD_NS 20
`define DEEP_SLEEP_ENTRY_NS 3000
`define DEEP_SLEEP_EXIT_NS 3000
`define DEEP_SLEEP_ENTRY_CYC (`DEEP_SLEEP_ENTRY_NS / `SYS_CLK_PERIOD_NS)
`define DEEP_SLEEP_EXIT_CYC (`DEEP_SLEEP_EXIT_NS / `SYS_CLK_PERIOD_NS)
`define TIMER_W 12

`endif

// file: hdl/flash_status_pkg.sv
package flash_status_pkg;

   typedef enum logic [1:0] {
      PWR_STANDBY,
      PWR_ENTERING,
      PWR_DEEP,
      PWR_EXITING
   } power_state_t;

   typedef enum logic [1:0] {
      CMD_IDLE,
      CMD_OPCODE,
      CMD_STATUS,
      CMD_IGNORE
   } cmd_state_t;

   // Live state from the array controller, same clock domain
   typedef struct packed {
      logic busy;
      logic compareMismatch;
      logic protectEnabled;
      logic pageSize512;
      logic opDone;
      logic opFailed;
      logic opAborted;
   } core_status_t;

   // Serial pins as seen after synchronisation
   typedef struct packed {
      logic chipSelect_n;
      logic serialClock;
      logic serialIn;
   } link_pins_t;

endpackage

// file: hdl/pin_sync.sv
`timescale 1ns/100ps

module pin_sync #(
   parameter int WIDTH = 3,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);

   logic [WIDTH-1:0] firstStage;

   initial begin
      if (WIDTH < 1) begin
         $error("pin_sync needs at least one bit");
      end
   end

   // Two flops per bit; only the second stage is read outside
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge sys_clk or negedge reset_n) begin
         if (!reset_n) begin
            firstStage[i] <= RESET_VALUE[i];
            syncOut[i] <= RESET_VALUE[i];
         end else begin
            firstStage[i] <= asyncIn[i];
            syncOut[i] <= firstStage[i];
         end
      end
   end

endmodule

// file: hdl/status_read_and_deep_sleep.sv
// Behaviour
// [R1] Opcode D7h starts a status read
// [R2] Drive one status bit per clock after opcode
// [R3] Repeat byte one, byte two while selected
// [R4] Capture live status at every byte start
// [R5] Status read served even while busy
// [R6] Bit 7 of both bytes: ready flag
// [R7] Deselect ends read, releases serial out
// [R8] Host polls until ready goes high
// [R9] Byte one bit 6: compare mismatch
// [R10] Byte one bits 5:2: fixed density code
// [R11] Byte one bit 1: protection enabled
// [R12] Byte one bit 0: 512-byte page configured
// [R13] Byte two bit 5: erase/program failure
// [R14] Failure flag updated per operation, not aborts
// [R15] Standby when deselected and not busy
// [R16] Opcode B9h then deselect enters deep sleep
// [R17] Partial opcode or odd bit count aborts
// [R18] Deep sleep ignores all but resume
// [R19] Sleep request ignored while busy
// [R20] Host resends sleep after busy ends
// [R21] Power-up starts in standby
// [R22] Opcode ABh then deselect leaves sleep
// [R23] Status bytes MSB first, byte one first
`timescale 1ns/100ps
`include "flash_status_params.svh"

module status_read_and_deep_sleep #(
   parameter logic [3:0] DENSITY_CODE = 4'h5, // Arbitrary value
   parameter int ENTRY_CYCLES = `DEEP_SLEEP_ENTRY_CYC,
   parameter int EXIT_CYCLES = `DEEP_SLEEP_EXIT_CYC
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic chipSelect_n,
   input wire logic serialClock,
   input wire logic serialIn,
   input wire flash_status_pkg::core_status_t coreStatus,
   output logic serialOut,
   output logic serialOutEnable,
   output logic deepSleep,
   output logic standbyMode
);

   initial begin
      if (ENTRY_CYCLES < 1 || ENTRY_CYCLES >= (1 << `TIMER_W)) begin
         $error("ENTRY_CYCLES out of range");
      end
      if (EXIT_CYCLES < 1 || EXIT_CYCLES >= (1 << `TIMER_W)) begin
         $error("EXIT_CYCLES out of range");
      end
   end

   localparam logic [`TIMER_W-1:0] ENTRY_LOAD = `TIMER_W'(ENTRY_CYCLES - 1);
   localparam logic [`TIMER_W-1:0] EXIT_LOAD = `TIMER_W'(EXIT_CYCLES - 1);
   localparam logic [`TIMER_W-1:0] TIMER_ZERO = '0;
   localparam flash_status_pkg::link_pins_t PINS_IDLE = '{
      chipSelect_n: 1'b1,
      serialClock: 1'b0,
      serialIn: 1'b0
   };

   // Pin synchronisation
   flash_status_pkg::link_pins_t rawPins;
   flash_status_pkg::link_pins_t pins;

   assign rawPins.chipSelect_n = chipSelect_n;
   assign rawPins.serialClock = serialClock;
   assign rawPins.serialIn = serialIn;

   pin_sync #(
      .WIDTH($bits(flash_status_pkg::link_pins_t)),
      .RESET_VALUE(PINS_IDLE)
   ) u_pin_sync (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .asyncIn(rawPins),
      .syncOut(pins)
   );

   // Edge detection on synchronised pins
   logic clockPrev;
   logic selectPrev_n;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         clockPrev <= 1'b0;
         selectPrev_n <= 1'b1;
      end else begin
         clockPrev <= pins.serialClock;
         selectPrev_n <= pins.chipSelect_n;
      end
   end

   wire selected = ~pins.chipSelect_n;
   wire selectFall = selectPrev_n & ~pins.chipSelect_n;
   wire selectRise = ~selectPrev_n & pins.chipSelect_n;
   wire clockRise = selected & ~selectFall & pins.serialClock & ~clockPrev;
   wire clockFall = selected & ~selectFall & ~pins.serialClock & clockPrev;

   // Live status bytes
   logic failFlag;
   wire [7:0] statusOne;
   wire [7:0] statusTwo;
   wire ready = ~coreStatus.busy;

   assign statusOne[`ST_READY_BIT] = ready; // [R6]
   assign statusOne[`ST1_COMPARE_BIT] = coreStatus.compareMismatch; // [R9]
   assign statusOne[`ST1_DENSITY_MSB:`ST1_DENSITY_LSB] = DENSITY_CODE; // [R10]
   assign statusOne[`ST1_PROTECT_BIT] = coreStatus.protectEnabled; // [R11]
   assign statusOne[`ST1_PAGE_BIT] = coreStatus.pageSize512; // [R12]

   assign statusTwo[`ST_READY_BIT] = ready; // [R6]
   assign statusTwo[`ST2_RSVD_HI_BIT] = 1'b0;
   assign statusTwo[`ST2_FAIL_BIT] = failFlag; // [R13]
   assign statusTwo[`ST2_RSVD_LO_MSB:`ST2_RSVD_LO_LSB] = `ST2_RSVD_LO_ZERO;

   // Erase/program failure flag
   wire failUpdate = coreStatus.opDone & ~coreStatus.opAborted;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         failFlag <= `FAIL_FLAG_RESET;
      end else if (failUpdate) begin
         failFlag <= coreStatus.opFailed; // [R14]
      end
   end

   // Command shifter
   flash_status_pkg::cmd_state_t cmdState;
   flash_status_pkg::power_state_t powerState;
   logic [`BYTE_BITS-1:0] opcode;
   logic [`BIT_CNT_W-1:0] bitCount;
   logic opcodeComplete;

   wire [`BYTE_BITS-1:0] next_opcode = {opcode[`BYTE_BITS-2:0], pins.serialIn};
   wire lastOpcodeBit = (bitCount == `BIT_CNT_LAST);
   wire isStatusRead = (next_opcode == `OPC_STATUS_READ); // [R1]
   wire statusAllowed = (powerState == flash_status_pkg::PWR_STANDBY); // [R5] [R18]
   wire onByteBoundary = opcodeComplete & (bitCount == `BIT_CNT_ZERO); // [R17]

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         opcode <= '0;
      end else if (selectFall) begin
         opcode <= '0;
      end else if (clockRise && cmdState == flash_status_pkg::CMD_OPCODE) begin
         opcode <= next_opcode;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         bitCount <= `BIT_CNT_ZERO;
      end else if (selectFall) begin
         bitCount <= `BIT_CNT_ZERO;
      end else if (clockRise) begin
         bitCount <= bitCount + 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         opcodeComplete <= 1'b0;
      end else if (selectFall) begin
         opcodeComplete <= 1'b0;
      end else if (clockRise && lastOpcodeBit) begin
         opcodeComplete <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cmdState <= flash_status_pkg::CMD_IDLE;
      end else begin
         case (cmdState)
            flash_status_pkg::CMD_IDLE: begin
               if (selectFall) begin
                  cmdState <= flash_status_pkg::CMD_OPCODE;
               end
            end
            flash_status_pkg::CMD_OPCODE: begin
               if (selectRise) begin
                  cmdState <= flash_status_pkg::CMD_IDLE;
               end else if (clockRise && lastOpcodeBit) begin
                  if (isStatusRead && statusAllowed) begin
                     cmdState <= flash_status_pkg::CMD_STATUS; // [R1]
                  end else begin
                     cmdState <= flash_status_pkg::CMD_IGNORE; // [R16] [R18]
                  end
               end
            end
            flash_status_pkg::CMD_STATUS: begin
               if (selectRise) begin
                  cmdState <= flash_status_pkg::CMD_IDLE; // [R7]
               end
            end
            flash_status_pkg::CMD_IGNORE: begin
               if (selectRise) begin
                  cmdState <= flash_status_pkg::CMD_IDLE;
               end
            end
            default: begin
               cmdState <= flash_status_pkg::CMD_IDLE;
            end
         endcase
      end
   end

   // Status output shifter
   logic [`STATUS_IDX_W-1:0] statusIdx;
   logic [`BYTE_BITS-1:0] shiftReg;

   wire shifting = clockFall & (cmdState == flash_status_pkg::CMD_STATUS); // [R2]
   wire byteStart = (statusIdx[`BIT_CNT_W-1:0] == `BIT_CNT_ZERO);
   wire [`BYTE_BITS-1:0] liveByte = statusIdx[`STATUS_BYTE_SEL] ? statusTwo : statusOne; // [R23]
   wire [`BYTE_BITS-1:0] nextSource = byteStart ? liveByte : shiftReg; // [R4]
   wire [`BYTE_BITS-1:0] next_shiftReg = {nextSource[`BYTE_BITS-2:0], 1'b0};

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         statusIdx <= `STATUS_IDX_ZERO;
      end else if (selectFall) begin
         statusIdx <= `STATUS_IDX_ZERO;
      end else if (shifting) begin
         statusIdx <= statusIdx + 1'b1; // [R3]
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         shiftReg <= '0;
      end else if (shifting) begin
         shiftReg <= next_shiftReg;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         serialOut <= `SERIAL_OUT_RESET;
      end else if (selectRise) begin
         serialOut <= `SERIAL_OUT_RESET;
      end else if (shifting) begin
         serialOut <= nextSource[`BYTE_BITS-1]; // [R23]
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         serialOutEnable <= 1'b0;
      end else if (selectRise || !selected) begin
         serialOutEnable <= 1'b0; // [R7]
      end else if (shifting) begin
         serialOutEnable <= 1'b1; // [R2]
      end
   end

   // Power state
   logic [`TIMER_W-1:0] powerTimer;

   wire lastOpcodeIsSleep = (opcode == `OPC_DEEP_SLEEP);
   wire lastOpcodeIsResume = (opcode == `OPC_RESUME);
   wire sleepRequest = selectRise & onByteBoundary & lastOpcodeIsSleep
      & ~coreStatus.busy; // [R16] [R17] [R19]
   wire resumeRequest = selectRise & onByteBoundary & lastOpcodeIsResume; // [R22]
   wire timerDone = (powerTimer == TIMER_ZERO);

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         powerState <= flash_status_pkg::PWR_STANDBY; // [R21]
      end else begin
         case (powerState)
            flash_status_pkg::PWR_STANDBY: begin
               if (sleepRequest) begin
                  powerState <= flash_status_pkg::PWR_ENTERING; // [R16]
               end
            end
            flash_status_pkg::PWR_ENTERING: begin
               if (timerDone) begin
                  powerState <= flash_status_pkg::PWR_DEEP;
               end
            end
            flash_status_pkg::PWR_DEEP: begin
               if (resumeRequest) begin
                  powerState <= flash_status_pkg::PWR_EXITING; // [R22]
               end
            end
            flash_status_pkg::PWR_EXITING: begin
               if (timerDone) begin
                  powerState <= flash_status_pkg::PWR_STANDBY;
               end
            end
            default: begin
               powerState <= flash_status_pkg::PWR_STANDBY;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         powerTimer <= TIMER_ZERO;
      end else if (powerState == flash_status_pkg::PWR_STANDBY && sleepRequest) begin
         powerTimer <= ENTRY_LOAD;
      end else if (powerState == flash_status_pkg::PWR_DEEP && resumeRequest) begin
         powerTimer <= EXIT_LOAD;
      end else if (!timerDone) begin
         powerTimer <= powerTimer - 1'b1;
      end
   end

   // Mode indicators
   wire next_deepSleep = (powerState == flash_status_pkg::PWR_DEEP);
   wire next_standbyMode = (powerState == flash_status_pkg::PWR_STANDBY)
      & pins.chipSelect_n & ~coreStatus.busy; // [R15]

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         deepSleep <= 1'b0;
         standbyMode <= 1'b0;
      end else begin
         deepSleep <= next_deepSleep;
         standbyMode <= next_standbyMode;
      end
   end

endmodule

// file: sim/status_read_and_deep_sleep_monitor.sv
`timescale 1ns/100ps

module status_read_and_deep_sleep_monitor #(
   parameter int EXIT_CYCLES = 4
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic chipSelect_n,
   input wire logic serialClock,
   input wire logic serialIn,
   input wire flash_status_pkg::core_status_t coreStatus,
   input wire logic serialOut,
   input wire logic serialOutEnable,
   input wire logic deepSleep,
   input wire logic standbyMode
);
   localparam int EXIT_LIM = EXIT_CYCLES + 4;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   a_deselect_release: assert property ($rose(chipSelect_n) |-> ##[1:5] !serialOutEnable)
      else $error("Serial out still enabled after deselect");
   a_sleep_silent: assert property (deepSleep |-> !serialOutEnable)
      else $error("Serial out enabled in deep sleep");
   a_sleep_not_standby: assert property (deepSleep |-> !standbyMode)
      else $error("Standby shown during deep sleep");
   a_busy_ends_standby: assert property ($rose(coreStatus.busy) |=> !standbyMode)
      else $error("Standby shown while busy");
   a_busy_blocks_sleep: assert property (coreStatus.busy && !deepSleep |=> !deepSleep)
      else $error("Deep sleep entered while busy");
   a_exit_to_standby: assert property ($fell(deepSleep) |-> ##[1:EXIT_LIM] standbyMode)
      else $error("Standby not reached after resume");
   a_enable_holds: assert property (serialOutEnable && !chipSelect_n |=> serialOutEnable)
      else $error("Serial out released while selected");
   a_shift_on_low: assert property (
      serialOutEnable && $past(serialOutEnable) && $changed(serialOut) |-> !serialClock)
      else $error("Serial out changed while serial clock high");
endmodule

bind status_read_and_deep_sleep status_read_and_deep_sleep_monitor #(
   .EXIT_CYCLES(EXIT_CYCLES)) u_mon (.sys_clk(sys_clk), .reset_n(reset_n),
   .chipSelect_n(chipSelect_n), .serialClock(serialClock), .serialIn(serialIn),
   .coreStatus(coreStatus), .serialOut(serialOut), .serialOutEnable(serialOutEnable),
   .deepSleep(deepSleep), .standbyMode(standbyMode));

// file: sim/spi_host_model.sv
`timescale 1ns/100ps

module spi_host_model (
   input wire logic sys_clk,
   input wire logic serialOut,
   input wire logic serialOutEnable,
   output logic chipSelect_n,
   output logic serialClock,
   output logic serialIn
);
   logic [23:0] rxData = '0;
   logic enSeen = 1'b0;

   // Mode 0: clock idles low and stands still between frames
   initial begin
      chipSelect_n = 1'b1;
      serialClock = 1'b0;
      serialIn = 1'b0;
   end

   // Opcode MSB first, then nIn bits sampled just before each rising edge
   task automatic xfer(input logic [7:0] opcode, input int nOut, input int nIn);
      int i;
      enSeen = 1'b0;
      @(posedge sys_clk);
      chipSelect_n <= 1'b0;
      for (i = 0; i < nOut + nIn; i++) begin
         serialIn <= (i < 8) ? opcode[7 - i] : ~serialIn;
         repeat (5) @(posedge sys_clk);
         enSeen = enSeen | serialOutEnable;
         if (i >= nOut) begin
            // A released line reads as the inverse of the last driven bit
            rxData = {rxData[22:0], serialOutEnable ? serialOut : ~serialOut};
         end
         serialClock <= 1'b1;
         repeat (3) @(posedge sys_clk);
         serialClock <= 1'b0;
      end
      repeat (5) @(posedge sys_clk);
      chipSelect_n <= 1'b1;
      serialIn <= ~serialIn;
      repeat (8) @(posedge sys_clk);
   endtask
endmodule

// file: sim/status_read_and_deep_sleep_tb_top.sv
`timescale 1ns/100ps

module status_read_and_deep_sleep_tb_top;
   localparam logic [3:0] DENS = 4'h9; // Arbitrary value
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   flash_status_pkg::core_status_t coreStatus = '0;
   logic chipSelect_n, serialClock, serialIn, serialOut, serialOutEnable, deepSleep, standbyMode;
   logic failExp = 1'b0;
   logic [7:0] e;
   logic [31:0] r;
   int error_cnt = 0;
   int checks_done = 0;
   int seed = 32'h08ab;
   int t;

   status_read_and_deep_sleep #(.DENSITY_CODE(DENS), .ENTRY_CYCLES(4), .EXIT_CYCLES(4)) uut (
      .sys_clk(sys_clk), .reset_n(reset_n), .chipSelect_n(chipSelect_n),
      .serialClock(serialClock), .serialIn(serialIn), .coreStatus(coreStatus),
      .serialOut(serialOut), .serialOutEnable(serialOutEnable), .deepSleep(deepSleep),
      .standbyMode(standbyMode));

   spi_host_model host (.sys_clk(sys_clk), .serialOut(serialOut),
      .serialOutEnable(serialOutEnable), .chipSelect_n(chipSelect_n),
      .serialClock(serialClock), .serialIn(serialIn));

   initial begin
      forever #10 sys_clk = ~sys_clk;
   end

   function automatic logic [7:0] byte_one(input flash_status_pkg::core_status_t s);
      return {~s.busy, s.compareMismatch, DENS, s.protectEnabled, s.pageSize512};
   endfunction

   function automatic logic [7:0] byte_two(input flash_status_pkg::core_status_t s, input logic f);
      return {~s.busy, 1'b0, f, 5'h00};
   endfunction

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic test_done();
      $display("Checks %0d, mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   task automatic wait_sleep(input logic exp);
      int i;
      for (i = 0; i < 300 && deepSleep !== exp; i++) begin
         @(posedge sys_clk);
      end
      check("deepSleep", {7'h0, deepSleep}, {7'h0, exp});
      if (deepSleep !== exp) begin
         test_done();
      end
   endtask

   task automatic op_end(input logic failed, input logic aborted);
      @(posedge sys_clk);
      coreStatus.opDone <= 1'b1;
      coreStatus.opFailed <= failed;
      coreStatus.opAborted <= aborted;
      @(posedge sys_clk);
      coreStatus.opDone <= 1'b0;
      if (!aborted) begin
         failExp = failed;
      end
   endtask

   initial begin
      idle(50000);
      error_cnt++;
      test_done();
   end

   initial begin
      idle(2);
      reset_n <= 1'b1;
      idle(4);
      check("standby", {7'h0, standbyMode}, 8'h01);
      check("sleep", {7'h0, deepSleep}, 8'h00);
      $display("Test power-up done");
      for (t = 0; t < 8; t++) begin
         r = $random(seed);
         op_end(r[4], t % 3 == 2);
         @(posedge sys_clk);
         coreStatus.busy <= (t == 0) ? 1'b1 : r[0];
         coreStatus.compareMismatch <= r[1];
         coreStatus.protectEnabled <= r[2];
         coreStatus.pageSize512 <= r[3];
         host.xfer(8'hd7, 8, 24);
         e = byte_one(coreStatus);
         check("byte one", host.rxData[23:16], e);
         check("byte two", host.rxData[15:8], byte_two(coreStatus, failExp));
         check("byte one again", host.rxData[7:0], e);
      end
      $display("Test status read done");
      @(posedge sys_clk);
      coreStatus.busy <= 1'b1;
      fork
         host.xfer(8'hd7, 8, 24);
         begin
            idle(97);
            coreStatus.busy <= 1'b0;
         end
      join
      check("busy byte one", host.rxData[23:16], {1'b0, e[6:0]});
      check("ready byte two", host.rxData[15:8], byte_two(coreStatus, failExp));
      check("ready byte one", host.rxData[7:0], {1'b1, e[6:0]});
      e = byte_one(coreStatus);
      $display("Test live busy poll done");
      host.xfer(8'hd7, 8, 5);
      check("partial", {3'h0, host.rxData[4:0]}, {3'h0, e[7:3]});
      host.xfer(8'h3c, 8, 8);
      check("other opcode", {7'h0, host.enSeen}, 8'h00);
      $display("Test partial and other opcode done");
      @(posedge sys_clk);
      coreStatus.busy <= 1'b1;
      host.xfer(8'hb9, 8, 0);
      idle(20);
      check("busy sleep", {7'h0, deepSleep}, 8'h00);
      coreStatus.busy <= 1'b0;
      idle(2);
      host.xfer(8'hb9, 16, 0);
      wait_sleep(1'b1);
      host.xfer(8'hd7, 8, 8);
      check("read in sleep", {7'h0, host.enSeen}, 8'h00);
      host.xfer(8'hab, 8, 0);
      wait_sleep(1'b0);
      idle(12);
      check("standby back", {7'h0, standbyMode}, 8'h01);
      $display("Test sleep and resume done");
      for (t = 4; t < 10; t += 5) begin
         host.xfer(8'hb9, t, 0);
         idle(20);
         check("aborted sleep", {7'h0, deepSleep}, 8'h00);
      end
      $display("Test aborted sleep done");
      op_end(1'b1, 1'b0);
      host.xfer(8'hb9, 8, 0);
      wait_sleep(1'b1);
      reset_n <= 1'b0;
      idle(2);
      reset_n <= 1'b1;
      failExp = 1'b0;
      idle(4);
      check("reset sleep", {7'h0, deepSleep}, 8'h00);
      check("reset standby", {7'h0, standbyMode}, 8'h01);
      host.xfer(8'hd7, 8, 16);
      check("reset byte one", host.rxData[15:8], e);
      check("reset byte two", host.rxData[7:0], byte_two(coreStatus, failExp));
      $display("Test mid-run reset done");
      test_done();
   end
endmodule
